// ### shared/vic_pkg.sv
// Purpose: Constants and types shared by the vectored interrupt controller.
// Assumes: Word-addressed program memory, two words per vector slot.
// Notes: Table bases are program-memory word addresses.
package vic_pkg;
  localparam int VIC_ADDR_W = 24;
  localparam int VIC_TRAP_SLOTS = 8;
  localparam int VIC_IRQ_SLOTS = 118;
  localparam int VIC_TABLE_SLOTS = VIC_TRAP_SLOTS + VIC_IRQ_SLOTS;
  localparam int VIC_MEM_DEPTH = 2 * VIC_TABLE_SLOTS;
  localparam int VIC_IDX_W = 8;
  localparam int VIC_VEC_W = 7;
  localparam int VIC_LVL_W = 3;
  localparam int VIC_CTL2_W = 16;
  localparam int VIC_ALT_SEL_BIT = 15;
  localparam logic [VIC_ADDR_W-1:0] VIC_PRI_BASE = 24'h000004;
  localparam logic [VIC_ADDR_W-1:0] VIC_SLOT_STEP = 24'h000002;
  localparam logic [VIC_ADDR_W-1:0] VIC_ALT_BASE =
    VIC_PRI_BASE + VIC_ADDR_W'(2 * VIC_TABLE_SLOTS);
  localparam logic [VIC_ADDR_W-1:0] VIC_RESET_PC = 24'h000000;
  localparam logic [VIC_LVL_W-1:0] VIC_LVL_NONE = 3'h0;
  localparam logic [VIC_VEC_W-1:0] VIC_IRQ_VEC0 = 7'h08;
  localparam logic [VIC_TRAP_SLOTS-1:0] VIC_TRAP_IMPL = 8'h1e;
  localparam logic [VIC_IRQ_SLOTS-1:0] VIC_IRQ_IMPL =
    118'h7e_0000_0000_20db_3fef;
  localparam int VIC_RET_CYC = 3;
  localparam int VIC_CNT_W = 2;
  typedef enum logic [5:0] {
    VIC_ST_IDLE = 6'b000001,
    VIC_ST_READ = 6'b000010,
    VIC_ST_LOAD = 6'b000100,
    VIC_ST_REQ = 6'b001000,
    VIC_ST_ACT = 6'b010000,
    VIC_ST_RET = 6'b100000
  } vic_state_t;
endpackage : vic_pkg

// ### shared/vic_vmem_if.sv
// Purpose: Carrier between the controller and its vector table store.
// Assumes: One clock; read data registered inside the store.
// Notes: Write side is the program-load path.
`timescale 1ns/1ps
interface vic_vmem_if;
  import vic_pkg::*;
  logic rd_en;
  logic [VIC_IDX_W-1:0] rd_idx;
  logic [VIC_ADDR_W-1:0] rd_data;
  logic wr_en;
  logic [VIC_IDX_W-1:0] wr_idx;
  logic [VIC_ADDR_W-1:0] wr_data;
  modport ctl (output rd_en, rd_idx, wr_en, wr_idx, wr_data, input rd_data);
  modport mem (input rd_en, rd_idx, wr_en, wr_idx, wr_data, output rd_data);
endinterface : vic_vmem_if

// ### src/vic_vector_mem.sv
// Purpose: Vector table store, primary table then alternate table.
// Assumes: One word per vector slot, indexed by slot number.
// Notes: Read data appear one edge after rd_en; array itself is not reset.
`timescale 1ns/1ps
module vic_vector_mem
  import vic_pkg::*;
#(
  parameter int DEPTH = VIC_TABLE_SLOTS * 2
) (
  input wire logic clk_i, // System clock
  input wire logic sys_rst_i, // Synchronous reset, active high
  vic_vmem_if.mem port_io // Read and load port
);
  logic [VIC_ADDR_W-1:0] mem_q [DEPTH];
  logic [VIC_ADDR_W-1:0] rd_data_q;

  always_ff @(posedge clk_i) begin
    if (port_io.wr_en && (int'(port_io.wr_idx) < DEPTH)) begin
      mem_q[port_io.wr_idx] <= port_io.wr_data;
    end
  end

  // Out-of-range slots read as the reset address
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rd_data_q <= VIC_RESET_PC;
    end else if (port_io.rd_en) begin
      if (int'(port_io.rd_idx) < DEPTH) begin
        rd_data_q <= mem_q[port_io.rd_idx];
      end else begin
        rd_data_q <= VIC_RESET_PC;
      end
    end
  end

  assign port_io.rd_data = rd_data_q;
endmodule : vic_vector_mem

// ### src/vic_ctrl.sv
// Purpose: Vectored interrupt controller merging peripheral and trap requests.
// Assumes: Requests, enables and levels come from logic on clk_i.
// Notes: One interrupt in service at a time; a trap may preempt it.
//
// Overview of operation
// - All requests merge into one core request.
// - Primary table starts at word 000004h.
// - 126 slots: 8 traps, then 118 interrupts.
// - Each slot holds a 24-bit routine address.
// - Every source owns a distinct table slot.
// - Lower trap slot wins; vector 1 highest.
// - Seven user levels; ties settle by slot.
// - Only 26 interrupts, 4 traps implemented.
// - Fixed entry latency and fixed return latency.
// - Alternate table follows primary; select bit 15.
// - Select bit set fetches from alternate table.
// - Alternate slots indexed exactly like primary.
// - Reset bypasses controller; PC forced to zero.
`timescale 1ns/1ps
module vic_ctrl
  import vic_pkg::*;
#(
  parameter logic [VIC_IRQ_SLOTS-1:0] IRQ_IMPL = VIC_IRQ_IMPL,
  parameter logic [VIC_TRAP_SLOTS-1:0] TRAP_IMPL = VIC_TRAP_IMPL,
  parameter int RET_CYC = VIC_RET_CYC
) (
  input wire logic clk_i, // System clock, 100 MHz
  input wire logic sys_rst_i, // Synchronous reset, active high
  input wire logic [VIC_TRAP_SLOTS-1:0] trap_req_i, // Trap request levels
  input wire logic [VIC_IRQ_SLOTS-1:0] irq_req_i, // Peripheral request levels
  input wire logic [VIC_IRQ_SLOTS-1:0] irq_en_i, // Per-source enables
  input wire logic [VIC_IRQ_SLOTS*VIC_LVL_W-1:0] irq_lvl_i, // Per-source level
  input wire logic [VIC_LVL_W-1:0] cpu_lvl_i, // Core's current level
  input wire logic [VIC_CTL2_W-1:0] interrupt_control_reg_two_i, // Control word
  input wire logic core_ack_i, // Core takes the request
  input wire logic core_ret_i, // Core returns from routine
  input wire logic load_we_i, // Table load strobe
  input wire logic [VIC_IDX_W-1:0] load_idx_i, // Table load slot
  input wire logic [VIC_ADDR_W-1:0] load_data_i, // Table load address value
  output logic core_irq_o, // Single request to the core
  output logic [VIC_VEC_W-1:0] vec_num_o, // Vector being served
  output logic [VIC_ADDR_W-1:0] table_addr_o, // Word address of fetched slot
  output logic [VIC_ADDR_W-1:0] pc_o, // Program counter load value
  output logic pc_load_o, // Load pc_o into the core
  output logic in_service_o, // A routine is running
  output logic ret_done_o // Return sequence complete
);
  vic_state_t state_q;
  vic_vmem_if vmem ();

  logic trap_hit;
  logic [VIC_VEC_W-1:0] trap_vec;
  logic irq_hit;
  logic [VIC_VEC_W-1:0] irq_vec;
  logic [VIC_LVL_W-1:0] best_lvl;
  logic [VIC_LVL_W-1:0] src_lvl;
  logic alt_table_select;
  logic accept;
  logic [VIC_VEC_W-1:0] win_vec;
  logic [VIC_IDX_W-1:0] slot_idx;
  logic [VIC_ADDR_W-1:0] table_base;
  logic [VIC_VEC_W-1:0] vec_q;
  logic alt_q;
  logic core_irq_q;
  logic [VIC_VEC_W-1:0] vec_num_q;
  logic [VIC_ADDR_W-1:0] table_addr_q;
  logic [VIC_ADDR_W-1:0] pc_q;
  logic pc_load_q;
  logic in_service_q;
  logic ret_done_q;
  logic [VIC_CNT_W-1:0] ret_cnt_q;

  assign alt_table_select = interrupt_control_reg_two_i[VIC_ALT_SEL_BIT];

  // Lowest implemented trap slot wins; no level or enable gates it
  always_comb begin
    trap_hit = 1'b0;
    trap_vec = '0;
    for (int i = VIC_TRAP_SLOTS - 1; i >= 0; i--) begin
      if (trap_req_i[i] && TRAP_IMPL[i]) begin
        trap_hit = 1'b1;
        trap_vec = VIC_VEC_W'(i);
      end
    end
  end

  // Highest user level wins; equal levels go to the lower slot
  always_comb begin
    irq_hit = 1'b0;
    irq_vec = '0;
    best_lvl = VIC_LVL_NONE;
    src_lvl = VIC_LVL_NONE;
    for (int i = VIC_IRQ_SLOTS - 1; i >= 0; i--) begin
      src_lvl = irq_lvl_i[i*VIC_LVL_W +: VIC_LVL_W];
      if (irq_req_i[i] && irq_en_i[i] && IRQ_IMPL[i]
          && (src_lvl > cpu_lvl_i) && (src_lvl >= best_lvl)) begin
        irq_hit = 1'b1;
        best_lvl = src_lvl;
        irq_vec = VIC_IRQ_VEC0 + VIC_VEC_W'(i);
      end
    end
  end

  // Any trap outranks every interrupt
  always_comb begin
    accept = 1'b0;
    win_vec = irq_vec;
    if (trap_hit) begin
      win_vec = trap_vec;
    end
    case (state_q)
      VIC_ST_IDLE: accept = trap_hit || irq_hit;
      VIC_ST_ACT: accept = trap_hit && !core_ret_i;
      default: accept = 1'b0;
    endcase
  end

  // Alternate slots sit at the same offset past the primary table
  always_comb begin
    slot_idx = VIC_IDX_W'(vec_q);
    table_base = VIC_PRI_BASE;
    if (alt_q) begin
      slot_idx = VIC_IDX_W'(vec_q) + VIC_IDX_W'(VIC_TABLE_SLOTS);
      table_base = VIC_ALT_BASE;
    end
  end

  assign vmem.rd_en = (state_q == VIC_ST_READ);
  assign vmem.rd_idx = slot_idx;
  assign vmem.wr_en = load_we_i;
  assign vmem.wr_idx = load_idx_i;
  assign vmem.wr_data = load_data_i;

  vic_vector_mem #(
    .DEPTH(VIC_TABLE_SLOTS * 2)
  ) u_table (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .port_io(vmem.mem)
  );

  // Fixed three edges from accept to request: read, load, present
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_q <= VIC_ST_IDLE;
    end else begin
      case (state_q)
        VIC_ST_IDLE: begin
          if (accept) begin
            state_q <= VIC_ST_READ;
          end
        end
        VIC_ST_READ: state_q <= VIC_ST_LOAD;
        VIC_ST_LOAD: state_q <= VIC_ST_REQ;
        VIC_ST_REQ: begin
          if (core_ack_i) begin
            state_q <= VIC_ST_ACT;
          end
        end
        VIC_ST_ACT: begin
          if (core_ret_i) begin
            state_q <= VIC_ST_RET;
          end else if (accept) begin
            state_q <= VIC_ST_READ;
          end
        end
        VIC_ST_RET: begin
          if (ret_cnt_q == '0) begin
            state_q <= VIC_ST_IDLE;
          end
        end
        default: state_q <= VIC_ST_IDLE;
      endcase
    end
  end

  // Winner and table choice are frozen at accept so the fetch cannot shift
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      vec_q <= '0;
      alt_q <= 1'b0;
    end else if (accept) begin
      vec_q <= win_vec;
      alt_q <= alt_table_select;
    end
  end

  // Word address of the slot: base plus two words per vector
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      table_addr_q <= VIC_RESET_PC;
      vec_num_q <= '0;
    end else if (state_q == VIC_ST_READ) begin
      table_addr_q <= table_base + VIC_SLOT_STEP * VIC_ADDR_W'(vec_q);
      vec_num_q <= vec_q;
    end
  end

  // Request line to the core
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      core_irq_q <= 1'b0;
    end else if (state_q == VIC_ST_LOAD) begin
      core_irq_q <= 1'b1;
    end else if (state_q == VIC_ST_REQ && core_ack_i) begin
      core_irq_q <= 1'b0;
    end
  end

  // During reset the core is told to start at zero, not through a vector
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pc_q <= VIC_RESET_PC;
      pc_load_q <= 1'b1;
    end else if (state_q == VIC_ST_LOAD) begin
      pc_q <= vmem.rd_data;
      pc_load_q <= 1'b0;
    end else if (state_q == VIC_ST_REQ && core_ack_i) begin
      pc_load_q <= 1'b1;
    end else begin
      pc_load_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      in_service_q <= 1'b0;
    end else if (state_q == VIC_ST_REQ && core_ack_i) begin
      in_service_q <= 1'b1;
    end else if (state_q == VIC_ST_ACT && core_ret_i) begin
      in_service_q <= 1'b0;
    end
  end

  // Return takes RET_CYC edges after the core's return strobe
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ret_cnt_q <= '0;
      ret_done_q <= 1'b0;
    end else begin
      ret_done_q <= 1'b0;
      if (state_q == VIC_ST_ACT && core_ret_i) begin
        ret_cnt_q <= VIC_CNT_W'(RET_CYC - 1);
      end else if (state_q == VIC_ST_RET) begin
        if (ret_cnt_q == '0) begin
          ret_done_q <= 1'b1;
        end else begin
          ret_cnt_q <= ret_cnt_q - 1'b1;
        end
      end
    end
  end

  assign core_irq_o = core_irq_q;
  assign vec_num_o = vec_num_q;
  assign table_addr_o = table_addr_q;
  assign pc_o = pc_q;
  assign pc_load_o = pc_load_q;
  assign in_service_o = in_service_q;
  assign ret_done_o = ret_done_q;
endmodule : vic_ctrl

// ### dv/vic_chk.sv
// Purpose: Port checks on the interrupt controller
// Assumes: One clock, synchronous active-high reset
// Notes: Bound to every vic_ctrl
`timescale 1ns/1ps
module vic_chk
  import vic_pkg::*;
(
  input wire logic clk_i, // Clock
  input wire logic sys_rst_i, // Reset
  input wire logic core_ack_i, // Ack
  input wire logic core_ret_i, // Return
  input wire logic core_irq_o, // Request
  input wire logic [VIC_VEC_W-1:0] vec_num_o, // Vector
  input wire logic [VIC_ADDR_W-1:0] table_addr_o, // Slot
  input wire logic [VIC_ADDR_W-1:0] pc_o, // Address
  input wire logic pc_load_o, // Load
  input wire logic in_service_o, // Busy
  input wire logic ret_done_o // Done
);
  logic [VIC_ADDR_W-1:0] off;
  assign off = {16'h0, vec_num_o, 1'b0};
  sequence take_s;
    core_irq_o && core_ack_i;
  endsequence
  sequence ret_s;
    in_service_o && core_ret_i;
  endsequence
  a_reset_pc_zero: assert property (@(posedge clk_i) sys_rst_i |=>
    pc_load_o && pc_o == '0 && !core_irq_o) else $error("reset left pc");
  a_ack_load: assert property (@(posedge clk_i) disable iff (sys_rst_i) take_s |=>
    !core_irq_o && pc_load_o && in_service_o ##1 !pc_load_o) else $error("ack");
  a_req_holds: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    core_irq_o && !core_ack_i |=> core_irq_o && $stable(pc_o)) else $error("hold");
  a_slot_addr: assert property (@(posedge clk_i) disable iff (sys_rst_i) core_irq_o |->
    table_addr_o == VIC_PRI_BASE + off || table_addr_o == VIC_ALT_BASE + off)
    else $error("slot");
  a_ret_latency: assert property (@(posedge clk_i) disable iff (sys_rst_i) ret_s |=>
    !in_service_o ##0 (!ret_done_o)[*3] ##1 ret_done_o) else $error("return");
  a_done_pulse: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ret_done_o |=> !ret_done_o) else $error("done");
  a_load_cause: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(pc_load_o) |-> $past(core_irq_o) && $past(core_ack_i)) else $error("load");
  a_impl_only: assert property (@(posedge clk_i) disable iff (sys_rst_i) core_irq_o |->
    (vec_num_o < VIC_IRQ_VEC0 ? VIC_TRAP_IMPL[vec_num_o[2:0]] :
    VIC_IRQ_IMPL[vec_num_o - VIC_IRQ_VEC0])) else $error("unused vector");
endmodule : vic_chk
bind vic_ctrl vic_chk u_chk (.clk_i, .sys_rst_i, .core_ack_i, .core_ret_i, .core_irq_o,
  .vec_num_o, .table_addr_o, .pc_o, .pc_load_o, .in_service_o, .ret_done_o);

// ### dv/vic_core_model.sv
// Purpose: Core that takes requests and returns from routines
// Assumes: Shares clock and reset with the controller
// Notes: Ack delay chosen per transfer, routine length fixed
`timescale 1ns/1ps
module vic_core_model #(
  parameter int SVC_CYC = 3
) (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic irq_i, // Request
  input wire logic busy_i, // Routine running
  input wire logic [1:0] dly_i, // Ack delay
  output logic ack_o, // Ack
  output logic ret_o // Return strobe
);
  logic [1:0] wait_q;
  logic [3:0] run_q;
  // Ack stays up until an edge has seen it with the request
  always_ff @(posedge clk_i) begin
    if (rst_i || !irq_i || ack_o) begin
      wait_q <= 2'h0;
      ack_o <= 1'b0;
    end else begin
      wait_q <= wait_q + 2'h1;
      ack_o <= wait_q >= dly_i;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || !busy_i || ret_o) begin
      run_q <= 4'h0;
      ret_o <= 1'b0;
    end else begin
      run_q <= run_q + 4'h1;
      ret_o <= run_q == 4'(SVC_CYC);
    end
  end
endmodule : vic_core_model

// ### dv/tb.sv
// Purpose: Self-checking bench for the interrupt controller
// Assumes: Core model answers acks and returns
// Notes: Table words encode slot and table
`timescale 1ns/1ps
module tb;
  import vic_pkg::*;
  logic clk_i, sys_rst_i, core_ack_i, core_ret_i, load_we_i, core_irq_o;
  logic pc_load_o, in_service_o, ret_done_o;
  logic [7:0] trap_req_i;
  logic [VIC_IRQ_SLOTS-1:0] irq_req_i, irq_en_i;
  logic [VIC_IRQ_SLOTS*3-1:0] irq_lvl_i;
  logic [2:0] cpu_lvl_i;
  logic [15:0] interrupt_control_reg_two_i;
  logic [7:0] load_idx_i;
  logic [23:0] load_data_i, table_addr_o, pc_o;
  logic [6:0] vec_num_o;
  logic [1:0] dly_q;
  logic [31:0] seed = 32'h4008a4db;
  logic alt_copy = 1'b0;
  int err_count, checked, cyc;
  vic_ctrl u_dut (.clk_i, .sys_rst_i, .trap_req_i, .irq_req_i, .irq_en_i, .irq_lvl_i,
    .cpu_lvl_i, .interrupt_control_reg_two_i, .core_ack_i, .core_ret_i, .load_we_i,
    .load_idx_i, .load_data_i, .core_irq_o, .vec_num_o, .table_addr_o, .pc_o,
    .pc_load_o, .in_service_o, .ret_done_o);
  vic_core_model u_core (.clk_i, .rst_i(sys_rst_i), .irq_i(core_irq_o),
    .busy_i(in_service_o), .dly_i(dly_q), .ack_o(core_ack_i), .ret_o(core_ret_i));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [23:0] word(input int v, input logic alt);
    return 24'h100000 + (alt ? 24'h010000 : 24'h0) + 24'(v);
  endfunction : word
  function automatic logic used(input int v);
    return v < 8 ? VIC_TRAP_IMPL[v] : VIC_IRQ_IMPL[v - 8];
  endfunction : used
  function automatic int pick();
    int w = -1;
    logic [2:0] best = 3'h0;
    for (int i = 0; i < 8; i++) if (trap_req_i[i] && VIC_TRAP_IMPL[i]) return i;
    for (int n = 0; n < VIC_IRQ_SLOTS; n++) begin
      if (VIC_IRQ_IMPL[n] && irq_req_i[n] && irq_en_i[n] && irq_lvl_i[n*3+:3] > best
          && irq_lvl_i[n*3+:3] > cpu_lvl_i) begin
        best = irq_lvl_i[n*3+:3];
        w = n + 8;
      end
    end
    return w;
  endfunction : pick
  task automatic chk(input string s, input logic [23:0] e, input logic [23:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim
  task automatic serve();
    int n = 1;
    int e;
    logic a;
    @(negedge clk_i);
    e = pick();
    a = interrupt_control_reg_two_i[VIC_ALT_SEL_BIT];
    while (core_irq_o !== 1'b1 && n < 12) begin
      @(negedge clk_i);
      n++;
    end
    if (e < 0) chk("idle", 24'h0, 24'(core_irq_o));
    else begin
      chk("latency", 24'h4, 24'(n));
      chk("vector", 24'(e), 24'(vec_num_o));
      chk("slot", (a ? VIC_ALT_BASE : VIC_PRI_BASE) + 24'(2 * e), table_addr_o);
      chk("pc", word(e, a && !alt_copy), pc_o);
    end
    @(posedge clk_i);
    trap_req_i <= '0;
    irq_req_i <= '0;
    n = 0;
    while (e >= 0 && ret_done_o !== 1'b1 && n < 30) begin
      @(negedge clk_i);
      n++;
    end
    if (e >= 0) chk("return", 24'h1, 24'(ret_done_o));
    @(posedge clk_i);
  endtask : serve
  task automatic drive(input logic [7:0] t, input logic [117:0] r, input logic [2:0] c);
    @(posedge clk_i);
    trap_req_i <= t;
    irq_req_i <= r;
    cpu_lvl_i <= c;
    serve();
  endtask : drive
  // Unused slots point at an arbitrary default handler address
  task automatic load_table(input logic copy);
    for (int i = 0; i < 253; i++) begin
      @(posedge clk_i);
      load_we_i <= 1'b1;
      load_idx_i <= 8'(i);
      load_data_i <= i > 251 ? 24'hffffff : !used(i % 126) ? 24'h000200
        : word(i % 126, i > 125 && !copy);
    end
    @(posedge clk_i);
    load_we_i <= 1'b0;
  endtask : load_table
  initial begin
    clk_i = 0;
    forever #5 clk_i = ~clk_i;
  end
  // Cuts a hang short
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      end_sim();
    end
  end
  initial begin
    {sys_rst_i, trap_req_i, irq_req_i, irq_en_i, irq_lvl_i, cpu_lvl_i} = '1;
    {interrupt_control_reg_two_i, load_we_i, load_idx_i, load_data_i, dly_q} = '0;
    trap_req_i = '0;
    irq_req_i = '0;
    repeat (16) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    load_table(1'b0);
    for (int a = 0; a < 2; a++) begin
      @(posedge clk_i);
      interrupt_control_reg_two_i <= {a[0], 15'h0};
      irq_en_i <= '0;
      for (int t = 0; t < 8; t++) drive(8'h01 << t, '0, 3'h7);
    end
    $display("test traps done");
    @(posedge clk_i);
    irq_en_i <= '1;
    irq_lvl_i <= {VIC_IRQ_SLOTS{3'h3}};
    drive(8'h10, VIC_IRQ_IMPL, 3'h2);
    drive(8'h00, VIC_IRQ_IMPL, 3'h2);
    drive(8'h00, VIC_IRQ_IMPL, 3'h3);
    drive(8'h00, 118'h10, 3'h0);
    $display("test corners done");
    repeat (60) begin
      @(posedge clk_i);
      for (int n = 0; n < VIC_IRQ_SLOTS; n++) begin
        seed = lfsr(seed);
        irq_req_i[n] <= seed[3:0] < 4'h3;
        irq_en_i[n] <= seed[9] | seed[7];
        irq_lvl_i[n*3+:3] <= seed[6:4];
      end
      trap_req_i <= seed[12:10] == 3'h0 ? 8'h01 << seed[2:0] : 8'h00;
      cpu_lvl_i <= seed[15:13];
      interrupt_control_reg_two_i <= seed[31:16];
      dly_q <= seed[1:0];
      serve();
    end
    $display("test random done");
    load_table(1'b1);
    alt_copy = 1'b1;
    interrupt_control_reg_two_i <= 16'h8000;
    irq_en_i <= '1;
    irq_lvl_i <= {VIC_IRQ_SLOTS{3'h3}};
    drive(8'h00, 118'h1, 3'h0);
    $display("test copy done");
    drive(8'h02, '0, 3'h7);
    @(posedge clk_i);
    trap_req_i <= 8'h04;
    repeat (4) @(posedge clk_i);
    // Drop the request with reset so the stale trap is not taken on release
    sys_rst_i <= 1'b1;
    trap_req_i <= '0;
    repeat (2) @(negedge clk_i);
    chk("rst_load", 24'h1, 24'(pc_load_o));
    chk("rst_pc", VIC_RESET_PC, pc_o);
    @(posedge clk_i);
    sys_rst_i <= 1'b0;
    drive(8'h08, '0, 3'h7);
    $display("test reset done");
    end_sim();
  end
endmodule : tb
